/* File: verilog/pss_defines.vh */
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH
// ==========================================
// register byte offsets
`define PSS_OFF_SLOT_CS      8'hd8
`define PSS_OFF_DEV_CAP2     8'he4
`define PSS_OFF_DEV_CS2      8'he8
`define PSS_OFF_LNK_CAP2     8'hec
`define PSS_OFF_LNK_CS2      8'hf0
`define PSS_OFF_SLOT_CAP2    8'hf4
`define PSS_OFF_SLOT_CS2     8'hf8
// ==========================================
// slot control half-word (low half of d8)
`define PSS_SC_ABP_EN        0
`define PSS_SC_PFD_EN        1
`define PSS_SC_PDC_EN        3
`define PSS_SC_CC_EN         4
`define PSS_SC_HPIE          5
`define PSS_SC_DLL_EN        12
`define PSS_SC_WMASK         16'h103b
// ==========================================
// slot status bits (upper half of d8)
`define PSS_SS_ABP           16
`define PSS_SS_PFD           17
`define PSS_SS_LSC           18
`define PSS_SS_PDC           19
`define PSS_SS_CC            20
`define PSS_SS_LATCH         21
`define PSS_SS_PRES          22
`define PSS_SS_DLL           24
`define PSS_SS_DLL_RST       1'h1
// ==========================================
// device capabilities 2 / control 2
`define PSS_DCAP2_LTR        11
`define PSS_DCAP2_OBFF_HI    19
`define PSS_DCAP2_OBFF_LO    18
`define PSS_DCAP2_OBFF_VAL   2'h1
`define PSS_DC2_LTR_EN       10
`define PSS_DC2_OBFF_HI      14
`define PSS_DC2_OBFF_LO      13
// ==========================================
// link control 2 fields
`define PSS_LC2_TLS_RST      4'h2
`define PSS_LC2_TLS_HI       3
`define PSS_LC2_ECOMP        4
`define PSS_LC2_HWSD         5
`define PSS_LC2_SDEEMP       6
`define PSS_LC2_TM_HI        9
`define PSS_LC2_TM_LO        7
`define PSS_LC2_EMC          10
`define PSS_LC2_CSOS         11
`define PSS_LC2_CDEEMP       12
`define PSS_LS2_CDL          16
`endif

/* File: verilog/pss_regs.v */
// Summary of operation
// RULE1 - button press sets bit 16, W1C
// RULE2 - power fault sets bit 17, W1C
// RULE3 - latch change bit 18, read-only
// RULE4 - presence change sets bit 19, W1C
// RULE5 - command done sets bit 20, W1C
// RULE6 - bit 21 shows latch open state
// RULE7 - bit 22 shows card presence
// RULE8 - no slot: presence bit reads one
// RULE9 - presence resets to inverse strap
// RULE10 - link-active change sets bit 24
// RULE11 - dev cap2 bit 11 reads one
// RULE12 - dev cap2 bits 19:18 read 01
// RULE13 - dev ctl2 bits 10, 14:13 writable
// RULE14 - upstream de-emphasis select reads zero
// RULE15 - downstream de-emphasis select reads one
// RULE16 - irq needs event enable and master enable
// RULE17 - link state notify needs bit 12
// RULE18 - W1C clears; new event beats clear
// RULE19 - sticky link ctl2 kept until power-on
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pss_defines.vh"

module pss_regs #(
	parameter DOWNSTREAM_PORT  = 1,  // port faces a slot side
	parameter SLOT_IMPLEMENTED = 1   // slot wired to this port
) (
	// clock and resets
	input  wire        CLK,
	input  wire        RESET,
	input  wire        POR_RESET,
	// avalon-mm slave
	input  wire [7:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	// slot pins, asynchronous
	input  wire        ATTN_BUTTON,
	input  wire        POWER_FAULT,
	input  wire        CARD_PRESENT,
	input  wire        LATCH_OPEN,
	input  wire        CARD_PRESENCE_STRAP,
	// core-clock status
	input  wire        CMD_DONE,
	input  wire        LINK_ACTIVE,
	input  wire        CUR_DEEMPHASIS,
	// outputs to the port
	output reg         HOTPLUG_IRQ,
	output reg         LTR_ENABLE,
	output reg  [1:0]  OBFF_ENABLE,
	output reg  [3:0]  TARGET_LINK_SPEED,
	output reg         HARDWARE_SPEED_CHANGE_DISABLE
);

	// ==========================================
	// address decode helper
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	// ==========================================
	// pin synchronisers
	localparam NSYNC = 5;

	wire [NSYNC-1:0] pin_raw;  // raw pin bundle
	reg  [NSYNC-1:0] s1_reg;   // first stage, only s2 reads
	reg  [NSYNC-1:0] s2_reg;   // second stage, usable
	reg  [NSYNC-1:0] s3_reg;   // history for edges

	assign pin_raw = {CARD_PRESENCE_STRAP, LATCH_OPEN, CARD_PRESENT,
		POWER_FAULT, ATTN_BUTTON};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			// two flops per pin, plus history
			always @(posedge CLK) begin
				s1_reg[gi] <= pin_raw[gi];
				s2_reg[gi] <= s1_reg[gi];
				s3_reg[gi] <= s2_reg[gi];
			end
		end
	endgenerate

	wire btn_s   = s2_reg[0];  // button level
	wire fault_s = s2_reg[1];  // fault level
	wire pres_s  = s2_reg[2];  // card level
	wire latch_s = s2_reg[3];  // latch open level
	wire strap_s = s2_reg[4];  // presence strap

	// edge events
	wire btn_rise   = btn_s & ~s3_reg[0];
	wire fault_rise = fault_s & ~s3_reg[1];
	wire pres_chg   = pres_s ^ s3_reg[2];
	wire latch_chg  = latch_s ^ s3_reg[3];

	// ==========================================
	// bus handshake
	reg  busy_reg;  // ack phase in progress
	wire req;       // any request present
	wire wr_do;     // write commits here
	wire [31:0] wmask;  // byte lane mask

	assign req   = AVS_READ | AVS_WRITE;
	assign wr_do = AVS_WRITE & ~AVS_WAITREQUEST;
	assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	wire [31:0] wd = AVS_WRITEDATA & wmask;  // lane-gated data

	// per-register write strobes
	wire wr_slot = wr_do & hit(AVS_ADDRESS, `PSS_OFF_SLOT_CS);
	wire wr_dc2  = wr_do & hit(AVS_ADDRESS, `PSS_OFF_DEV_CS2);
	wire wr_lc2  = wr_do & hit(AVS_ADDRESS, `PSS_OFF_LNK_CS2);

	// ==========================================
	// slot control and status state
	reg  [15:0] slot_ctl_reg;  // enables and master enable
	reg  abp_reg;   // button pressed flag
	reg  pfd_reg;   // power fault flag
	reg  lsc_reg;   // latch changed flag
	reg  pdc_reg;   // presence changed flag
	reg  cc_reg;    // command completed flag
	reg  dll_reg;   // link state changed flag
	reg  pres_reg;  // presence state
	reg  lat_reg;   // latch state
	reg  la_d_reg;  // previous link active

	// clear masks, only on written lanes
	wire clr_abp = wr_slot & wd[`PSS_SS_ABP];
	wire clr_pfd = wr_slot & wd[`PSS_SS_PFD];
	wire clr_pdc = wr_slot & wd[`PSS_SS_PDC];
	wire clr_cc  = wr_slot & wd[`PSS_SS_CC];
	wire clr_dll = wr_slot & wd[`PSS_SS_DLL];
	wire la_chg  = LINK_ACTIVE ^ la_d_reg;

	// next values: set beats clear
	wire abp_next = btn_rise | (abp_reg & ~clr_abp);     // RULE1 RULE18
	wire pfd_next = fault_rise | (pfd_reg & ~clr_pfd);   // RULE2 RULE18
	wire pdc_next = pres_chg | (pdc_reg & ~clr_pdc);     // RULE4 RULE18
	wire cc_next  = CMD_DONE | (cc_reg & ~clr_cc);       // RULE5 RULE18
	wire dll_next = la_chg | (dll_reg & ~clr_dll);       // RULE10 RULE18
	wire lsc_next = latch_chg | lsc_reg;                 // RULE3

	// slot control merge, lane-aware
	wire [15:0] sc_wmask = wmask[15:0] & `PSS_SC_WMASK;
	wire [15:0] slot_ctl_next = wr_slot ?
		((slot_ctl_reg & ~sc_wmask) | (AVS_WRITEDATA[15:0] & sc_wmask)) :
		slot_ctl_reg;

	// flags, states and slot control
	always @(posedge CLK) begin
		if (RESET) begin
			slot_ctl_reg <= 16'h0000;
			abp_reg      <= 1'b0;  // RULE1
			pfd_reg      <= 1'b0;  // RULE2
			lsc_reg      <= 1'b0;  // RULE3
			pdc_reg      <= 1'b0;  // RULE4
			cc_reg       <= 1'b0;  // RULE5
			dll_reg      <= `PSS_SS_DLL_RST;  // RULE10
			lat_reg      <= 1'b0;  // RULE6
			pres_reg     <= ~strap_s;  // RULE9
			la_d_reg     <= LINK_ACTIVE;
		end else begin
			slot_ctl_reg <= slot_ctl_next;
			abp_reg      <= abp_next;
			pfd_reg      <= pfd_next;
			lsc_reg      <= lsc_next;
			pdc_reg      <= pdc_next;
			cc_reg       <= cc_next;
			dll_reg      <= dll_next;
			lat_reg      <= latch_s;  // RULE6
			pres_reg     <= pres_s;   // RULE7
			la_d_reg     <= LINK_ACTIVE;
		end
	end

	// presence seen by software
	wire pres_rd = (SLOT_IMPLEMENTED != 0) ? pres_reg : 1'b1;  // RULE8

	// ==========================================
	// device control 2
	reg       ltr_en_reg;   // latency report enable
	reg [1:0] obff_en_reg;  // flush/fill mode

	// writable fields only
	always @(posedge CLK) begin
		if (RESET) begin
			ltr_en_reg  <= 1'b0;   // RULE13
			obff_en_reg <= 2'h0;   // RULE13
		end else if (wr_dc2) begin
			if (AVS_BYTEENABLE[1]) begin
				ltr_en_reg  <= AVS_WRITEDATA[`PSS_DC2_LTR_EN];  // RULE13
				obff_en_reg <= AVS_WRITEDATA[`PSS_DC2_OBFF_HI:`PSS_DC2_OBFF_LO];  // RULE13
			end
		end
	end

	// ==========================================
	// link control 2
	reg [3:0] tls_reg;     // target link speed
	reg       ecomp_reg;   // enter compliance
	reg [2:0] tm_reg;      // transmit margin
	reg       emc_reg;     // modified compliance
	reg       csos_reg;    // compliance skip
	reg       cdeemp_reg;  // compliance de-emphasis
	reg       hwsd_reg;    // speed change disable

	// sticky fields, power-on only
	always @(posedge CLK) begin
		if (POR_RESET) begin
			tls_reg    <= `PSS_LC2_TLS_RST;  // RULE19
			ecomp_reg  <= 1'b0;
			tm_reg     <= 3'h0;
			emc_reg    <= 1'b0;
			csos_reg   <= 1'b0;
			cdeemp_reg <= 1'b0;
		end else if (wr_lc2) begin
			if (AVS_BYTEENABLE[0]) begin
				tls_reg   <= AVS_WRITEDATA[`PSS_LC2_TLS_HI:0];  // RULE19
				ecomp_reg <= AVS_WRITEDATA[`PSS_LC2_ECOMP];
				tm_reg[0] <= AVS_WRITEDATA[`PSS_LC2_TM_LO];
			end
			if (AVS_BYTEENABLE[1]) begin
				tm_reg[2:1] <= AVS_WRITEDATA[`PSS_LC2_TM_HI:`PSS_LC2_TM_LO+1];
				emc_reg     <= AVS_WRITEDATA[`PSS_LC2_EMC];
				csos_reg    <= AVS_WRITEDATA[`PSS_LC2_CSOS];
				cdeemp_reg  <= AVS_WRITEDATA[`PSS_LC2_CDEEMP];
			end
		end
	end

	// non-sticky field, port reset
	always @(posedge CLK) begin
		if (RESET | POR_RESET) begin
			hwsd_reg <= 1'b0;
		end else if (wr_lc2 & AVS_BYTEENABLE[0]) begin
			hwsd_reg <= AVS_WRITEDATA[`PSS_LC2_HWSD];
		end
	end

	// de-emphasis select by port role
	wire sel_deemp = (DOWNSTREAM_PORT != 0) ? 1'b1 : 1'b0;  // RULE14 RULE15

	// ==========================================
	// read data assembly
	reg [31:0] rd_word;  // selected register image

	always @* begin
		rd_word = 32'h0000_0000;  // unmapped reads zero
		if (hit(AVS_ADDRESS, `PSS_OFF_SLOT_CS)) begin
			rd_word[15:0]         = slot_ctl_reg;
			rd_word[`PSS_SS_ABP]   = abp_reg;
			rd_word[`PSS_SS_PFD]   = pfd_reg;
			rd_word[`PSS_SS_LSC]   = lsc_reg;   // RULE3
			rd_word[`PSS_SS_PDC]   = pdc_reg;
			rd_word[`PSS_SS_CC]    = cc_reg;
			rd_word[`PSS_SS_LATCH] = lat_reg;   // RULE6
			rd_word[`PSS_SS_PRES]  = pres_rd;   // RULE7 RULE8
			rd_word[`PSS_SS_DLL]   = dll_reg;
		end else if (hit(AVS_ADDRESS, `PSS_OFF_DEV_CAP2)) begin
			rd_word[`PSS_DCAP2_LTR] = 1'b1;  // RULE11
			rd_word[`PSS_DCAP2_OBFF_HI:`PSS_DCAP2_OBFF_LO] = `PSS_DCAP2_OBFF_VAL;  // RULE12
		end else if (hit(AVS_ADDRESS, `PSS_OFF_DEV_CS2)) begin
			rd_word[`PSS_DC2_LTR_EN] = ltr_en_reg;  // RULE13
			rd_word[`PSS_DC2_OBFF_HI:`PSS_DC2_OBFF_LO] = obff_en_reg;
		end else if (hit(AVS_ADDRESS, `PSS_OFF_LNK_CS2)) begin
			rd_word[`PSS_LC2_TLS_HI:0] = tls_reg;
			rd_word[`PSS_LC2_ECOMP]    = ecomp_reg;
			rd_word[`PSS_LC2_HWSD]     = hwsd_reg;
			rd_word[`PSS_LC2_SDEEMP]   = sel_deemp;  // RULE14 RULE15
			rd_word[`PSS_LC2_TM_HI:`PSS_LC2_TM_LO] = tm_reg;
			rd_word[`PSS_LC2_EMC]      = emc_reg;
			rd_word[`PSS_LC2_CSOS]     = csos_reg;
			rd_word[`PSS_LC2_CDEEMP]   = cdeemp_reg;
			rd_word[`PSS_LS2_CDL]      = CUR_DEEMPHASIS;
		end
		// e8 upper, ec, f4, f8 read zero
	end

	// ==========================================
	// handshake: one wait cycle per access
	always @(posedge CLK) begin
		if (RESET) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
			busy_reg        <= 1'b0;
		end else if (req & AVS_WAITREQUEST & ~busy_reg) begin
			// accept: answer next edge
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA    <= AVS_READ ? rd_word : 32'h0000_0000;
			busy_reg        <= 1'b1;
		end else begin
			// done: back to waiting
			AVS_WAITREQUEST <= 1'b1;
			busy_reg        <= 1'b0;
		end
	end

	// ==========================================
	// hot-plug interrupt and port outputs
	wire ev_pend =
		(abp_reg & slot_ctl_reg[`PSS_SC_ABP_EN]) |
		(pfd_reg & slot_ctl_reg[`PSS_SC_PFD_EN]) |
		(pdc_reg & slot_ctl_reg[`PSS_SC_PDC_EN]) |
		(cc_reg  & slot_ctl_reg[`PSS_SC_CC_EN]);
	wire dll_pend = dll_reg & slot_ctl_reg[`PSS_SC_DLL_EN];  // RULE17

	// registered outputs
	always @(posedge CLK) begin
		if (RESET) begin
			HOTPLUG_IRQ <= 1'b0;
			LTR_ENABLE  <= 1'b0;
			OBFF_ENABLE <= 2'h0;
			HARDWARE_SPEED_CHANGE_DISABLE <= 1'b0;
		end else begin
			HOTPLUG_IRQ <= slot_ctl_reg[`PSS_SC_HPIE] & (ev_pend | dll_pend);  // RULE16
			LTR_ENABLE  <= ltr_en_reg;
			OBFF_ENABLE <= obff_en_reg;
			HARDWARE_SPEED_CHANGE_DISABLE <= hwsd_reg;
		end
	end

	// sticky speed copy, port reset must not touch it
	always @(posedge CLK) begin
		if (POR_RESET) begin
			TARGET_LINK_SPEED <= `PSS_LC2_TLS_RST;  // RULE19
		end else begin
			TARGET_LINK_SPEED <= tls_reg;  // RULE19
		end
	end

endmodule

/* File: verif/pss_regs_monitor.sv */
`timescale 1ns/1ps
// ==========
// port checker
module pss_regs_monitor #(
	parameter DOWNSTREAM_PORT = 1  // mirrors dut
) (
	// clock and resets
	input wire        CLK,
	input wire        RESET,
	input wire        POR_RESET,
	// bus
	input wire [7:0]  AVS_ADDRESS,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0]  AVS_BYTEENABLE,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	// status and outputs
	input wire        CMD_DONE,
	input wire        LINK_ACTIVE,
	input wire        HOTPLUG_IRQ,
	input wire        LTR_ENABLE,
	input wire [1:0]  OBFF_ENABLE,
	input wire [3:0]  TARGET_LINK_SPEED
);
	reg  hpie_q;  // shadow of master enable
	reg  cc_q;    // shadow of command enable
	reg  dll_q;   // shadow of link enable
	wire wr_d8 = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[7:2] == 6'h36;
	wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
	// track committed slot control writes
	always @(posedge CLK) begin
		if (RESET) begin
			hpie_q <= 1'b0;
			cc_q   <= 1'b0;
			dll_q  <= 1'b0;
		end else if (wr_d8) begin
			if (AVS_BYTEENABLE[0]) begin
				hpie_q <= AVS_WRITEDATA[5];
				cc_q   <= AVS_WRITEDATA[4];
			end
			if (AVS_BYTEENABLE[1]) begin
				dll_q  <= AVS_WRITEDATA[12];
			end
		end
	end
	property p_dc2_copy;
		@(posedge CLK) disable iff (RESET)
		AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1] && AVS_ADDRESS[7:2] == 6'h3a |-> ##2
		LTR_ENABLE == $past(AVS_WRITEDATA[10], 2) && OBFF_ENABLE == $past(AVS_WRITEDATA[14:13], 2);
	endproperty
	a_dc2_copy: assert property (p_dc2_copy) else $error("dev ctl2 copy wrong");
	property p_tls_keep;
		@(posedge CLK) disable iff (POR_RESET)
		RESET && $past(RESET) |-> $stable(TARGET_LINK_SPEED);
	endproperty
	a_tls_keep: assert property (p_tls_keep) else $error("speed lost in port reset");
	property p_tls_por;
		@(posedge CLK) disable iff (RESET)
		POR_RESET [*3] |-> TARGET_LINK_SPEED == 4'h2;
	endproperty
	a_tls_por: assert property (p_tls_por) else $error("speed not 2 after power-on");
	property p_irq_off;
		@(posedge CLK) disable iff (RESET)
		!hpie_q && !$past(hpie_q) |-> !HOTPLUG_IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without master enable");
	property p_cmd_irq;
		@(posedge CLK) disable iff (RESET)
		CMD_DONE && cc_q && hpie_q |-> ##2 HOTPLUG_IRQ;
	endproperty
	a_cmd_irq: assert property (p_cmd_irq) else $error("no irq on command done");
	property p_link_irq;
		@(posedge CLK) disable iff (RESET)
		$changed(LINK_ACTIVE) && dll_q && hpie_q |-> ##2 HOTPLUG_IRQ;
	endproperty
	a_link_irq: assert property (p_link_irq) else $error("no irq on link change");
	property p_cap2_read;
		@(posedge CLK) disable iff (RESET)
		rd_ok && AVS_ADDRESS[7:2] == 6'h39 |-> AVS_READDATA == 32'h0004_0800;
	endproperty
	a_cap2_read: assert property (p_cap2_read) else $error("dev cap2 value wrong");
	property p_deemp_read;
		@(posedge CLK) disable iff (RESET)
		rd_ok && AVS_ADDRESS[7:2] == 6'h3c |-> AVS_READDATA[6] == (DOWNSTREAM_PORT != 0);
	endproperty
	a_deemp_read: assert property (p_deemp_read) else $error("de-emphasis select wrong");
endmodule
bind pss_regs pss_regs_monitor #(.DOWNSTREAM_PORT(DOWNSTREAM_PORT)) mon (.CLK(CLK), .RESET(RESET),
	.POR_RESET(POR_RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.CMD_DONE(CMD_DONE), .LINK_ACTIVE(LINK_ACTIVE), .HOTPLUG_IRQ(HOTPLUG_IRQ), .LTR_ENABLE(LTR_ENABLE),
	.OBFF_ENABLE(OBFF_ENABLE), .TARGET_LINK_SPEED(TARGET_LINK_SPEED));

/* File: verif/pss_regs_bench.sv */
`timescale 1ns/1ps
// ==========
// register bench
module pss_regs_bench;
	reg         clk = 0, rst = 1, por = 1;           // clock, resets
	reg  [7:0]  addr = 0;                            // bus request
	reg         rd_en = 0, wr_en = 0;
	reg  [31:0] wdata = 0;
	wire [31:0] rdata, up_rd;                        // bus answers
	wire        waitreq, irq, ltr, hwsd;
	reg  [3:0]  be = 4'hf;                           // byte lanes
	reg         strap = 0, cdeemp = 0;               // strap and link status
	wire [1:0]  obff;
	wire [3:0]  tls;
	reg         attn = 0, pf = 0, card = 1, latch = 0; // slot pins
	reg         cmd = 0, link = 0;                   // core status
	reg  [31:0] got, got_up;                         // captured read data
	integer     n_mismatch = 0, samples_checked = 0, cyc = 0;
	// downstream port with slot
	pss_regs #(.DOWNSTREAM_PORT(1), .SLOT_IMPLEMENTED(1)) dut (.CLK(clk), .RESET(rst), .POR_RESET(por),
		.AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .ATTN_BUTTON(attn),
		.POWER_FAULT(pf), .CARD_PRESENT(card), .LATCH_OPEN(latch), .CARD_PRESENCE_STRAP(strap),
		.CMD_DONE(cmd), .LINK_ACTIVE(link), .CUR_DEEMPHASIS(cdeemp), .HOTPLUG_IRQ(irq), .LTR_ENABLE(ltr),
		.OBFF_ENABLE(obff), .TARGET_LINK_SPEED(tls), .HARDWARE_SPEED_CHANGE_DISABLE(hwsd));
	// upstream-style port without slot, same bus
	pss_regs #(.DOWNSTREAM_PORT(0), .SLOT_IMPLEMENTED(0)) dut_up (.CLK(clk), .RESET(rst), .POR_RESET(por),
		.AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(up_rd), .AVS_WAITREQUEST(), .ATTN_BUTTON(attn),
		.POWER_FAULT(pf), .CARD_PRESENT(card), .LATCH_OPEN(latch), .CARD_PRESENCE_STRAP(strap),
		.CMD_DONE(cmd), .LINK_ACTIVE(link), .CUR_DEEMPHASIS(cdeemp), .HOTPLUG_IRQ(), .LTR_ENABLE(),
		.OBFF_ENABLE(), .TARGET_LINK_SPEED(), .HARDWARE_SPEED_CHANGE_DISABLE());
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			results;
		end
	end
	// verdict
	task results;
		begin
			$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
			if (n_mismatch == 0 && samples_checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// compare one value
	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("FAIL %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	// one avalon access, held until waitrequest low
	task bus(input [7:0] a, input w, input [31:0] d);
		integer t;
		begin
			t = 0;
			@(posedge clk);
			addr <= a;
			rd_en <= ~w;
			wr_en <= w;
			wdata <= d;
			@(posedge clk);
			while (waitreq !== 1'b0 && t < 50) begin
				@(posedge clk);
				t = t + 1;
			end
			if (t == 50) chk(32'h0000_0000, 32'h0000_0001);
			got = rdata;
			got_up = up_rd;
			rd_en <= 1'b0;
			wr_en <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			bus(a, 1'b0, 32'h0000_0000);
			chk(got, e);
		end
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		por <= 0;
		rd(8'hd8, 32'h0140_0000);
		chk({31'h0, got_up[22]}, 32'h1);
		rd(8'he4, 32'h0004_0800);
		rd(8'hf0, 32'h0000_0042);
		chk({31'h0, got_up[6]}, 32'h0);
		rd(8'hec, 32'h0000_0000);
		rd(8'hf4, 32'h0000_0000);
		rd(8'hf8, 32'h0000_0000);
		rd(8'hfc, 32'h0000_0000);
		bus(8'he8, 1'b1, 32'hffff_ffff);
		rd(8'he8, 32'h0000_6400);
		chk({29'h0, ltr, obff}, 32'h7);
		be <= 4'h1;
		bus(8'he8, 1'b1, 32'h0000_0000);
		be <= 4'hf;
		rd(8'he8, 32'h0000_6400);
		bus(8'hd8, 1'b1, 32'h0100_1010);
		rd(8'hd8, 32'h0040_1010);
		@(posedge clk) cmd <= 1;
		@(posedge clk) cmd <= 0;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(8'hd8, 32'h0050_1010);
		bus(8'hd8, 1'b1, 32'h0000_1030);
		rd(8'hd8, 32'h0050_1030);
		chk({31'h0, irq}, 32'h1);
		bus(8'hd8, 1'b1, 32'h0010_1030);
		rd(8'hd8, 32'h0040_1030);
		chk({31'h0, irq}, 32'h0);
		@(posedge clk) link <= 1;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(8'hd8, 32'h0140_1030);
		bus(8'hd8, 1'b1, 32'h0100_1030);
		@(posedge clk) {attn, pf, latch, card} <= 4'b1110;
		repeat (6) @(posedge clk);
		rd(8'hd8, 32'h002f_1030);
		bus(8'hd8, 1'b1, 32'h01ff_1030);
		rd(8'hd8, 32'h0024_1030);
		bus(8'hf0, 1'b1, 32'h0000_0023);
		rd(8'hf0, 32'h0000_0063);
		chk({31'h0, hwsd}, 32'h1);
		@(posedge clk) rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
		rd(8'hf0, 32'h0000_0043);
		chk({28'h0, tls}, 32'h3);
		@(posedge clk) por <= 1;
		repeat (4) @(posedge clk);
		por <= 0;
		cdeemp <= 1;
		rd(8'hf0, 32'h0001_0042);
		results;
	end
endmodule
